// ==== logic/parallel_flash_config_reader.sv ====
`timescale 1ns/100ps
module parallel_flash_config_reader
    import flash_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // board pins
    input  wire logic              i_full_reset_n,
    input  wire logic              i_init_hold_n,
    input  wire logic              i_config_done,
    input  wire logic              i_external_config_clock_in,
    input  wire logic [DATA_W-1:0] i_flash_data,
    // configuration options
    input  wire logic              i_bus_width_16,
    input  wire logic [RATE_W-1:0] i_internal_clock_rate_setting,
    input  wire logic              i_external_clock_select,
    input  wire logic [DIV_W-1:0]  i_external_clock_divisor,
    input  wire logic [REL_W-1:0]  i_tristate_release_cycle,
    input  wire logic              i_user_drive_config_clock,
    input  wire logic              i_user_config_clock_level,
    // from the bitstream interpreter
    input  wire logic              i_clock_switch_request,
    // configuration clock pin
    output logic                   o_config_clock,
    output logic                   o_config_clock_oe,
    // flash pins
    output logic [ADDR_W-1:0]      o_flash_address,
    output logic                   o_flash_address_oe,
    output logic                   o_flash_chip_select_n,
    output logic                   o_flash_chip_select_n_oe,
    output logic                   o_flash_output_enable_n,
    output logic                   o_flash_output_enable_n_oe,
    output logic                   o_flash_write_enable_n,
    output logic                   o_flash_write_enable_n_oe,
    // bitstream words
    output logic [DATA_W-1:0]      o_word_data,
    output logic                   o_word_valid,
    output logic [CNT_W-1:0]       o_word_count,
    // status
    output logic                   o_config_active,
    output logic                   o_user_mode,
    output logic                   o_clock_is_external,
    output logic                   o_address_overflow
);

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_WAIT   = 5'b00001,
        ST_FIRST  = 5'b00010,
        ST_STREAM = 5'b00100,
        ST_FINISH = 5'b01000,
        ST_USER   = 5'b10000
    } reader_state_t;

    typedef struct packed {
        reader_state_t     st;
        logic [ADDR_W-1:0] addr;
        logic [HOLD_W-1:0] hold_cnt;
        logic [REL_W-1:0]  rel_cnt;
        logic [DATA_W-1:0] word;
        logic              word_valid;
        logic [CNT_W-1:0]  word_count;
        logic              overflow;
        logic              clk_pin;
        logic              clk_pin_oe;
    } reader_regs_t;

    localparam reader_regs_t REGS_RESET = '{
        st:         ST_WAIT,
        addr:       ADDR_FIRST,
        hold_cnt:   '0,
        rel_cnt:    '0,
        word:       '0,
        word_valid: 1'b0,
        word_count: '0,
        overflow:   1'b0,
        clk_pin:    1'b0,
        clk_pin_oe: 1'b0
    };

    reader_regs_t q;
    reader_regs_t d;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic [DATA_W-1:0] data_s;
    logic              done_s;
    logic              full_reset_n_s;
    logic              init_hold_n_s;
    logic              ext_clock_s;

    // data is stable for half a clock period, far longer than the sync delay
    always_comb begin
        pins_async                                     = '0;
        pins_async[SYNC_DATA_LSB +: DATA_W]            = i_flash_data;
        pins_async[SYNC_DONE]                          = i_config_done;
        pins_async[SYNC_FULL_RESET]                    = i_full_reset_n;
        pins_async[SYNC_INIT_HOLD]                     = i_init_hold_n;
        pins_async[SYNC_EXT_CLOCK]                     = i_external_config_clock_in;
    end

    pin_synchronizer u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (pins_async),
        .o_sync  (pins_sync)
    );

    assign data_s         = pins_sync[SYNC_DATA_LSB +: DATA_W];
    assign done_s         = pins_sync[SYNC_DONE];
    assign full_reset_n_s = pins_sync[SYNC_FULL_RESET];
    assign init_hold_n_s  = pins_sync[SYNC_INIT_HOLD];
    assign ext_clock_s    = pins_sync[SYNC_EXT_CLOCK];

    // ---------------------------------------------------------------
    // configuration clock
    // ---------------------------------------------------------------
    logic run_clock;
    logic cfg_clk;
    logic cfg_rise;
    logic cfg_fall;
    logic using_ext;
    logic switch_ok;

    assign run_clock = (q.st != ST_WAIT) && (q.st != ST_USER);
    // the switch setting only counts while the bitstream is being read
    assign switch_ok = i_clock_switch_request && ((q.st == ST_FIRST) || (q.st == ST_STREAM));

    config_clock_gen u_clock_gen (
        .i_clk            (i_clk),
        .i_rst_n          (i_rst_n),
        .i_run            (run_clock),
        .i_rate           (i_internal_clock_rate_setting),
        .i_ext_allowed    (i_external_clock_select),
        .i_switch_request (switch_ok),
        .i_divisor        (i_external_clock_divisor),
        .i_ext_level      (ext_clock_s),
        .o_config_clock   (cfg_clk),
        .o_rise           (cfg_rise),
        .o_fall           (cfg_fall),
        .o_using_external (using_ext)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // an 8-bit flash only drives the low lane; the upper lane reads as zero
    function automatic logic [DATA_W-1:0] bus_word(input logic [DATA_W-1:0] raw,
                                                   input logic              wide);
        if (wide) begin
            return raw;
        end
        return {{(DATA_W - BYTE_W){1'b0}}, raw[BYTE_W-1:0]};
    endfunction

    // ---------------------------------------------------------------
    // reader sequence
    // ---------------------------------------------------------------
    always_comb begin
        d            = q;
        d.word_valid = 1'b0;
        d.clk_pin    = cfg_clk;
        d.clk_pin_oe = 1'b1;

        case (q.st)
            ST_WAIT: begin
                d.addr     = ADDR_FIRST;
                d.hold_cnt = '0;
                d.rel_cnt  = '0;
                // start only once both hold-off pins read high
                if (full_reset_n_s && init_hold_n_s) begin
                    d.st = ST_FIRST;
                end
            end

            ST_FIRST: begin
                // the first address stays put while the flash wakes up
                d.addr = ADDR_FIRST;
                if (done_s) begin
                    d.st = ST_FINISH;
                end else if (cfg_rise) begin
                    if (q.hold_cnt >= FIRST_HOLD_CYCLES - HOLD_W'(1)) begin
                        d.word       = bus_word(data_s, i_bus_width_16);
                        d.word_valid = 1'b1;
                        d.word_count = q.word_count + CNT_W'(1);
                        d.st         = ST_STREAM;
                    end else begin
                        d.hold_cnt = q.hold_cnt + HOLD_W'(1);
                    end
                end
            end

            ST_STREAM: begin
                if (done_s) begin
                    d.st = ST_FINISH;
                end else begin
                    if (cfg_fall) begin
                        // one word per cycle; the top address holds and flags
                        if (q.addr == ADDR_LAST) begin
                            d.overflow = 1'b1;
                        end else begin
                            d.addr = q.addr + ADDR_W'(1);
                        end
                    end
                    if (cfg_rise) begin
                        d.word       = bus_word(data_s, i_bus_width_16);
                        d.word_valid = 1'b1;
                        d.word_count = q.word_count + CNT_W'(1);
                    end
                end
            end

            ST_FINISH: begin
                // startup keeps clocking, but nothing more is captured
                if (q.rel_cnt >= i_tristate_release_cycle) begin
                    d.st = ST_USER;
                end else if (cfg_rise) begin
                    d.rel_cnt = q.rel_cnt + REL_W'(1);
                end
            end

            ST_USER: begin
                // the clock pin goes quiet unless the user design claims it
                d.clk_pin    = i_user_config_clock_level;
                d.clk_pin_oe = i_user_drive_config_clock;
            end

            default: begin
                d = REGS_RESET;
            end
        endcase

        // the full-reset pin restarts the whole sequence from any state
        if (!full_reset_n_s) begin
            d = REGS_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    logic reading;

    assign reading = (q.st == ST_FIRST) || (q.st == ST_STREAM) || (q.st == ST_FINISH);

    // before start and after release the flash pins float on their pulls
    assign o_flash_address            = q.addr;
    assign o_flash_address_oe         = reading;
    assign o_flash_chip_select_n      = !reading;
    assign o_flash_chip_select_n_oe   = reading;
    assign o_flash_output_enable_n    = !reading;
    assign o_flash_output_enable_n_oe = reading;
    assign o_flash_write_enable_n     = 1'b1;
    assign o_flash_write_enable_n_oe  = reading;

    // before start the clock pin is driven low, but it floats while the full-reset pin reads low
    assign o_config_clock      = q.clk_pin;
    assign o_config_clock_oe   = q.clk_pin_oe;

    // ---------------------------------------------------------------
    // status
    // ---------------------------------------------------------------
    assign o_word_data         = q.word;
    assign o_word_valid        = q.word_valid;
    assign o_word_count        = q.word_count;
    assign o_config_active     = reading;
    assign o_user_mode         = (q.st == ST_USER);
    assign o_clock_is_external = using_ext;
    assign o_address_overflow  = q.overflow;

endmodule

// ==== logic/flash_cfg_pkg.sv ====
package flash_cfg_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int RATE_W = 8;
    localparam int DIV_W  = 10;
    localparam int HOLD_W = 4;
    localparam int REL_W  = 3;
    localparam int CNT_W  = 27;

    // ---------------------------------------------------------------
    // timing and defaults
    // ---------------------------------------------------------------
    localparam int                CLK_FREQ_MHZ          = 250;
    localparam int                CLK_PERIOD_NS         = 4;
    localparam logic [RATE_W-1:0] DEFAULT_RATE_MHZ      = 8'h02;
    localparam logic [DIV_W-1:0]  DEFAULT_DIVISOR       = 10'h001;
    localparam logic [DIV_W-1:0]  MAX_DIVISOR           = 10'h3FE;
    localparam logic [HOLD_W-1:0] FIRST_HOLD_CYCLES     = 4'h8;
    localparam logic [REL_W-1:0]  DEFAULT_RELEASE_CYCLE = 3'h1;

    // ---------------------------------------------------------------
    // address range and synchroniser lanes
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 26'h0000000;
    localparam logic [ADDR_W-1:0] ADDR_LAST  = 26'h3FFFFFF;
    localparam int SYNC_W          = 20;
    localparam int SYNC_DATA_LSB   = 0;
    localparam int SYNC_DONE       = 16;
    localparam int SYNC_FULL_RESET = 17;
    localparam int SYNC_INIT_HOLD  = 18;
    localparam int SYNC_EXT_CLOCK  = 19;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 20'h00000;

    // half period of the internal clock in system cycles; a rate of 0 falls back
    function automatic logic [DIV_W-1:0] half_period_cycles(input logic [RATE_W-1:0] rate);
        int r;
        int c;
        r = (rate == 8'h00) ? int'(DEFAULT_RATE_MHZ) : int'(rate);
        c = CLK_FREQ_MHZ / (2 * r);
        if (c < 1) begin
            c = 1;
        end
        return DIV_W'(c);
    endfunction

    // 0 acts as 1, odd values above 1 drop to the even value below
    function automatic logic [DIV_W-1:0] divisor_eff(input logic [DIV_W-1:0] div);
        if (div <= DEFAULT_DIVISOR) begin
            return DEFAULT_DIVISOR;
        end
        if (div > MAX_DIVISOR) begin
            return MAX_DIVISOR;
        end
        return {div[DIV_W-1:1], 1'b0};
    endfunction

endpackage

// ==== logic/pin_synchronizer.sv ====
`timescale 1ns/100ps
module pin_synchronizer
    import flash_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // pins
    input  wire logic [SYNC_W-1:0] i_async,
    output logic      [SYNC_W-1:0] o_sync
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] held;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // a lane changes only when stages two and three agree; s1 feeds s2 only
    always_comb begin
        d    = q;
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.held[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '{SYNC_RESET, SYNC_RESET, SYNC_RESET, SYNC_RESET};
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.held;

endmodule

// ==== logic/config_clock_gen.sv ====
`timescale 1ns/100ps
module config_clock_gen
    import flash_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // control
    input  wire logic              i_run,
    input  wire logic [RATE_W-1:0] i_rate,
    input  wire logic              i_ext_allowed,
    input  wire logic              i_switch_request,
    input  wire logic [DIV_W-1:0]  i_divisor,
    input  wire logic              i_ext_level,
    // generated clock
    output logic                   o_config_clock,
    output logic                   o_rise,
    output logic                   o_fall,
    output logic                   o_using_external
);

    typedef struct packed {
        logic             clk;
        logic [DIV_W-1:0] cnt;
        logic             ext_prev;
        logic             pending;
        logic             use_ext;
        logic             rise;
        logic             fall;
    } clkgen_state_t;

    clkgen_state_t    q;
    clkgen_state_t    d;
    logic             tick;
    logic             ext_edge;
    logic             want_switch;
    logic [DIV_W-1:0] cnt_inc;

    always_comb begin
        d           = q;
        tick        = 1'b0;
        d.rise      = 1'b0;
        d.fall      = 1'b0;
        d.ext_prev  = i_ext_level;
        ext_edge    = (i_ext_level != q.ext_prev);
        cnt_inc     = q.cnt + DIV_W'(1);
        want_switch = q.pending || (i_switch_request && i_ext_allowed);
        if (!i_run) begin
            // every new run starts on the internal source
            d.clk     = 1'b0;
            d.cnt     = '0;
            d.use_ext = 1'b0;
            d.pending = 1'b0;
        end else begin
            if (i_switch_request && i_ext_allowed && !q.use_ext) begin
                d.pending = 1'b1;
            end
            if (q.use_ext) begin
                // each external edge is one half period before division
                if (ext_edge) begin
                    if (cnt_inc >= divisor_eff(i_divisor)) begin
                        tick = 1'b1;
                    end else begin
                        d.cnt = cnt_inc;
                    end
                end
            end else if (cnt_inc >= half_period_cycles(i_rate)) begin
                tick = 1'b1;
            end else begin
                d.cnt = cnt_inc;
            end
            if (tick) begin
                d.cnt  = '0;
                d.clk  = !q.clk;
                d.rise = !q.clk;
                d.fall = q.clk;
                // change source only as the clock falls, so no runt phase
                if (q.clk && !q.use_ext && want_switch) begin
                    d.use_ext = 1'b1;
                    d.pending = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_config_clock   = q.clk;
    assign o_rise           = q.rise;
    assign o_fall           = q.fall;
    assign o_using_external = q.use_ext;

endmodule

// ==== tb/flash_reader_properties.sv ====
`timescale 1ns/100ps
module flash_reader_properties
    import flash_cfg_pkg::*;
(
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    // pins and options
    input wire logic              i_full_reset_n,
    input wire logic              i_init_hold_n,
    input wire logic              i_config_done,
    input wire logic              i_external_clock_select,
    input wire logic              i_user_drive_config_clock,
    // outputs watched
    input wire logic              o_config_clock,
    input wire logic              o_config_clock_oe,
    input wire logic [ADDR_W-1:0] o_flash_address,
    input wire logic              o_flash_address_oe,
    input wire logic              o_flash_chip_select_n,
    input wire logic              o_flash_chip_select_n_oe,
    input wire logic              o_flash_output_enable_n,
    input wire logic              o_flash_output_enable_n_oe,
    input wire logic              o_flash_write_enable_n,
    input wire logic              o_flash_write_enable_n_oe,
    input wire logic              o_word_valid,
    input wire logic              o_config_active,
    input wire logic              o_user_mode,
    input wire logic              o_clock_is_external
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ----
    // properties
    // ----
    a_addr_on_fall: assert property (o_config_active && $past(o_config_active) &&
        $changed(o_flash_address) |-> !o_config_clock && $past(o_config_clock))
        else $error("address moved away from a clock fall");
    a_addr_step: assert property (o_config_active && $past(o_config_active) &&
        $changed(o_flash_address) |-> o_flash_address == $past(o_flash_address) + 26'h1)
        else $error("address did not advance by one");
    a_capture_rise: assert property (o_word_valid |->
        o_config_clock && !$past(o_config_clock))
        else $error("word captured away from a clock rise");
    a_pins_drive: assert property (o_config_active |-> !o_flash_chip_select_n &&
        !o_flash_output_enable_n && o_flash_write_enable_n && o_flash_chip_select_n_oe &&
        o_flash_output_enable_n_oe && o_flash_write_enable_n_oe && o_flash_address_oe)
        else $error("flash pins not driven while reading");
    a_pins_release: assert property (o_user_mode |-> !(o_flash_chip_select_n_oe ||
        o_flash_output_enable_n_oe || o_flash_write_enable_n_oe || o_flash_address_oe))
        else $error("flash pins still driven in user mode");
    a_stop_on_done: assert property (i_config_done [*6] |-> !o_word_valid)
        else $error("word read after completion");
    a_start_gate: assert property ($rose(o_config_active) |->
        $past(i_full_reset_n, 2) && $past(i_init_hold_n, 2))
        else $error("reading started while held off");
    a_clk_user: assert property (o_user_mode && $past(o_user_mode) &&
        $stable(i_user_drive_config_clock) |-> o_config_clock_oe == i_user_drive_config_clock)
        else $error("clock pin drive ignores the user setting");
    a_switch_gate: assert property (!i_external_clock_select && !o_clock_is_external
        |=> !o_clock_is_external)
        else $error("clock went external without the select");
endmodule

bind parallel_flash_config_reader flash_reader_properties u_flash_reader_properties (.*);

// ==== tb/flash_nor_model.sv ====
`timescale 1ns/100ps
module flash_nor_model
    import flash_cfg_pkg::*;
#(
    parameter int ACC_NS = 20
) (
    // flash pins from the reader
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_output_enable_n,
    input  wire logic              i_select_driven,
    // data pins to the reader
    output logic      [DATA_W-1:0] o_data
);
    logic selected;
    assign selected = !i_chip_select_n && !i_output_enable_n && i_select_driven;
    initial o_data = 16'h0000;
    // powered and ready from time zero; stale data is inverted so it never looks valid
    always @(i_address, selected) begin
        o_data = ~o_data;
        if (selected) begin
            o_data <= #ACC_NS i_address[15:0] ^ 16'h3C5A;
        end
    end
endmodule

// ==== tb/parallel_flash_config_reader_tb.sv ====
`timescale 1ns/100ps
module parallel_flash_config_reader_tb;
    import flash_cfg_pkg::*;
    // ----
    // wiring
    // ----
    logic i_clk, i_rst_n, i_full_reset_n, i_init_hold_n, i_config_done, i_bus_width_16;
    logic i_external_config_clock_in, i_external_clock_select, i_clock_switch_request;
    logic i_user_drive_config_clock, i_user_config_clock_level;
    logic [DATA_W-1:0] i_flash_data, o_word_data;
    logic [RATE_W-1:0] i_internal_clock_rate_setting;
    logic [DIV_W-1:0]  i_external_clock_divisor;
    logic [REL_W-1:0]  i_tristate_release_cycle;
    logic [ADDR_W-1:0] o_flash_address;
    logic [CNT_W-1:0]  o_word_count;
    logic o_config_clock, o_config_clock_oe, o_flash_address_oe, o_flash_chip_select_n;
    logic o_flash_chip_select_n_oe, o_flash_output_enable_n, o_flash_output_enable_n_oe;
    logic o_flash_write_enable_n, o_flash_write_enable_n_oe, o_word_valid, o_config_active;
    logic o_user_mode, o_clock_is_external, o_address_overflow;
    int   n_mismatch = 0, comparisons = 0, rises = 0, seen_words = 0, n, r0;

    parallel_flash_config_reader u_parallel_flash_config_reader (.*);
    flash_nor_model u_flash_nor_model (
        .i_address        (o_flash_address),
        .i_chip_select_n  (o_flash_chip_select_n),
        .i_output_enable_n(o_flash_output_enable_n),
        .i_select_driven  (o_flash_chip_select_n_oe),
        .o_data           (i_flash_data)
    );

    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end
    // board oscillator, 24 ns period, runs free
    initial begin
        i_external_config_clock_in = 1'h0;
        forever #12 i_external_config_clock_in = ~i_external_config_clock_in;
    end
    always @(posedge o_config_clock) rises++;
    always @(posedge i_clk) if (o_word_valid === 1'h1) seen_words++;

    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    function automatic logic probe(input int s);
        case (s)
            0: return o_config_active;
            1: return o_word_valid;
            2: return o_clock_is_external;
            3: return o_user_mode;
            default: return o_config_clock;
        endcase
    endfunction
    task automatic wait_on(input int s, input logic lvl);
        int i;
        for (i = 0; i < 3000 && probe(s) !== lvl; i++) step(1);
        if (i == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic high_len(output int c);
        wait_on(4, 1'h0);
        wait_on(4, 1'h1);
        for (c = 0; c < 3000 && o_config_clock === 1'h1; c++) step(1);
    endtask
    task automatic read_words(input int cnt, input logic [15:0] mask);
        repeat (cnt) begin
            step(1);
            wait_on(1, 1'h1);
            chk(o_flash_address, 26'(seen_words));
            chk(o_word_data, (16'(seen_words) ^ 16'h3C5A) & mask);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        i_rst_n = 1'h0;
        i_full_reset_n = 1'h0;
        i_init_hold_n = 1'h1;
        i_config_done = 1'h0;
        i_bus_width_16 = 1'h1;
        i_internal_clock_rate_setting = 8'h0A;
        i_external_clock_select = 1'h0;
        i_external_clock_divisor = 10'h004;
        i_tristate_release_cycle = 3'h1;
        i_user_drive_config_clock = 1'h1;
        i_user_config_clock_level = 1'h1;
        i_clock_switch_request = 1'h0;
        step(2);
        i_rst_n = 1'h1;
        step(20);
        chk(o_config_active, 1'h0);
        i_full_reset_n = 1'h1;
        i_init_hold_n = 1'h0;
        step(20);
        chk(o_flash_chip_select_n_oe, 1'h0);
        i_init_hold_n = 1'h1;
        wait_on(0, 1'h1);
        r0 = rises;
        chk({o_flash_chip_select_n, o_flash_write_enable_n}, 2'h1);
        high_len(n);
        chk(n, 32'h0000000C);
        read_words(1, 16'hFFFF);
        chk(rises - r0, 32'h00000008);
        read_words(4, 16'hFFFF);
        i_external_clock_select = 1'h1;
        i_clock_switch_request = 1'h1;
        step(1);
        i_clock_switch_request = 1'h0;
        wait_on(2, 1'h1);
        high_len(n);
        chk(n >= 11 && n <= 13, 1'h1);
        read_words(2, 16'hFFFF);
        wait_on(4, 1'h0);
        wait_on(4, 1'h1);
        i_config_done = 1'h1;
        r0 = rises;
        step(6);
        n = seen_words;
        wait_on(3, 1'h1);
        chk(rises - r0, 32'h00000001);
        step(40);
        chk(seen_words, n);
        chk({o_config_clock_oe, o_config_clock}, 2'h3);
        i_user_drive_config_clock = 1'h0;
        step(3);
        chk(o_config_clock_oe, 1'h0);
        i_config_done = 1'h0;
        i_bus_width_16 = 1'h0;
        i_external_clock_select = 1'h0;
        i_full_reset_n = 1'h0;
        step(10);
        i_full_reset_n = 1'h1;
        wait_on(0, 1'h1);
        seen_words = 0;
        read_words(2, 16'h00FF);
        report_and_stop();
    end
endmodule
